/* shared/bes_pkg.sv */
// Constants and types shared by the downstream error signalling block.
// Assumes a single core clock domain; all event inputs are synchronous pulses.
package bes_pkg;

    // ------------------------------------------------------------------
    // Error classes (index into severity, mask and status vectors)
    // ------------------------------------------------------------------
    localparam int BES_NCLASS = 3;
    localparam int BES_CLS_POISON = 0;
    localparam int BES_CLS_ECRC = 1;
    localparam int BES_CLS_DATAERR = 2;

    // Severity: bit set means fatal, clear means non-fatal
    localparam logic [BES_NCLASS-1:0] BES_SEV_RESET = 3'h6;
    localparam logic [BES_NCLASS-1:0] BES_MASK_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Message kinds and their one-hot request positions
    // ------------------------------------------------------------------
    localparam int BES_NMSG = 3;
    localparam int BES_REQ_FATAL = 0;
    localparam int BES_REQ_NONFATAL = 1;
    localparam int BES_REQ_COR = 2;

    typedef enum logic [1:0] {
        BES_MSG_COR,
        BES_MSG_NONFATAL,
        BES_MSG_FATAL
    } bes_msg_e;

    // ------------------------------------------------------------------
    // Completion status encodings on the PCIe side
    // ------------------------------------------------------------------
    localparam logic [2:0] BES_CPL_SC = 3'h0;
    localparam logic [2:0] BES_CPL_UR = 3'h1;
    localparam logic [2:0] BES_CPL_CA = 3'h4;

    // Immediate termination seen on the secondary bus
    typedef enum logic [1:0] {
        BES_TERM_NORMAL,
        BES_TERM_DATAERR,
        BES_TERM_MABORT,
        BES_TERM_TABORT
    } bes_term_e;

    localparam int BES_DW = 32;
    localparam int BES_IDW = 16;

endpackage

/* shared/bes_msg_if.sv */
// Carries message requests from the error core to the message sender.
// Both ends sit on the core clock.
`timescale 1ns/10ps
interface bes_msg_if;
    import bes_pkg::*;
    logic [BES_NMSG-1:0] request;
    logic busy;

    modport core (output request, input busy);
    modport sender (input request, output busy);
endinterface

/* design/bes_msg_sender.sv */
// Message sender: holds pending error message requests and issues them one
// at a time upstream. Assumes the upstream port accepts on valid and ready.
`timescale 1ns/10ps
module bes_msg_sender
    import bes_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // From the error core
    bes_msg_if.sender req,
    // Upstream message port
    input wire logic [BES_IDW-1:0] requesterId,
    input wire logic msgReady,
    output logic msgValid,
    output bes_msg_e msgType,
    output logic [BES_IDW-1:0] msgRequesterId
);

    // ------------------------------------------------------------------
    // Pending flags and output stage
    // ------------------------------------------------------------------
    logic [BES_NMSG-1:0] pending;
    logic [BES_NMSG-1:0] next_pending;
    logic next_msgValid;
    bes_msg_e next_msgType;
    logic [BES_IDW-1:0] next_msgRequesterId;
    logic [BES_NMSG-1:0] taken;

    assign req.busy = msgValid;

    always_comb begin
        taken = '0;
        next_msgValid = msgValid;
        next_msgType = msgType;
        next_msgRequesterId = msgRequesterId;
        if (msgValid && msgReady) begin
            next_msgValid = 1'b0;
        end
        // one packet per pending flag; repeated requests merge while pending
        // Valid drops for one cycle between messages so each packet is distinct
        if (!msgValid) begin
            if (pending[BES_REQ_FATAL]) begin
                taken[BES_REQ_FATAL] = 1'b1;
                next_msgType = BES_MSG_FATAL;
            end else if (pending[BES_REQ_NONFATAL]) begin
                taken[BES_REQ_NONFATAL] = 1'b1;
                next_msgType = BES_MSG_NONFATAL;
            end else if (pending[BES_REQ_COR]) begin
                taken[BES_REQ_COR] = 1'b1;
                next_msgType = BES_MSG_COR;
            end
            if (|taken) begin
                next_msgValid = 1'b1;
                next_msgRequesterId = requesterId;
            end
        end
        // A new request in the cycle its flag is taken stays pending
        next_pending = (pending & ~taken) | req.request;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= '0;
            msgValid <= 1'b0;
            msgType <= BES_MSG_COR;
            msgRequesterId <= '0;
        end else begin
            pending <= next_pending;
            msgValid <= next_msgValid;
            msgType <= next_msgType;
            msgRequesterId <= next_msgRequesterId;
        end
    end

endmodule

/* design/bridge_error_signaling.sv */
// Downstream error detection, reporting and completion translation core.
// Assumes all inputs come from logic on the same core clock.
// Operation
// - Errors set bridge and link status, message
// - Per-class severity, reset default, software writable
// - Fatal/nonfatal message needs system or class enable
// - Correctable message only with correctable enable
// - Seen bits set regardless of enables
// - Unmasked advisory nonfatal sends correctable instead
// - Poisoned payload forwarded with inverted parity
// - ECRC-bad request dropped, nothing forwarded
// - Read data error: successful, poisoned completion
// - Nonposted write data error: unsupported request
// - Master-abort UR, target-abort completer abort
`timescale 1ns/10ps
module bridge_error_signaling
    import bes_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Reporting controls
    input wire logic system_error_enable,
    input wire logic fatal_report_enable,
    input wire logic nonfatal_report_enable,
    input wire logic correctable_report_enable,
    input wire logic advisory_nonfatal_mask,
    input wire logic [BES_NCLASS-1:0] uncorrMask,
    input wire logic [BES_IDW-1:0] requesterId,
    // Severity programming
    input wire logic severityWrite,
    input wire logic [BES_NCLASS-1:0] severityData,
    output logic [BES_NCLASS-1:0] severityFatal,
    // Status clear pulses, one per sticky bit
    input wire logic clearFatalSeen,
    input wire logic clearNonfatalSeen,
    input wire logic clearCorrectableSeen,
    input wire logic clearParityDetected,
    input wire logic clearSystemErrorSignaled,
    input wire logic clearAdvisory,
    input wire logic [BES_NCLASS-1:0] clearUncorrStatus,
    // Status
    output logic fatal_seen,
    output logic nonfatal_seen,
    output logic correctable_seen,
    output logic parityDetected,
    output logic systemErrorSignaled,
    output logic advisorySeen,
    output logic [BES_NCLASS-1:0] uncorrStatus,
    // Downstream data phases from the link
    input wire logic dnValid,
    input wire logic [BES_DW-1:0] dnData,
    input wire logic dnPoisoned,
    input wire logic dnEcrcBad,
    input wire logic dnLast,
    output logic dnReady,
    // Data phases toward the secondary bus
    input wire logic secReady,
    output logic secValid,
    output logic [BES_DW-1:0] secData,
    output logic secParity,
    output logic secLast,
    // Immediate termination of a forwarded non-posted request
    input wire logic termValid,
    input wire bes_term_e termKind,
    input wire logic termIsRead,
    output logic cplValid,
    output logic [2:0] cplStatus,
    output logic cplPoisoned,
    // Upstream error messages
    input wire logic msgReady,
    output logic msgValid,
    output bes_msg_e msgType,
    output logic [BES_IDW-1:0] msgRequesterId
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic evenParity(input logic [BES_DW-1:0] d);
        return ^d;
    endfunction

    bes_msg_if msgBus ();

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    logic next_secValid;
    logic [BES_DW-1:0] next_secData;
    logic next_secParity;
    logic next_secLast;
    logic accept;
    logic poisonEvent;
    logic ecrcEvent;

    // Output register frees when empty or drained
    assign dnReady = !secValid || secReady;
    assign accept = dnValid && dnReady;
    // Events are counted once per packet, on its last phase
    assign poisonEvent = accept && dnLast && dnPoisoned && !dnEcrcBad;
    assign ecrcEvent = accept && dnLast && dnEcrcBad;

    always_comb begin
        next_secValid = secValid;
        next_secData = secData;
        next_secParity = secParity;
        next_secLast = secLast;
        if (secValid && secReady) begin
            next_secValid = 1'b0;
        end
        if (accept && !dnEcrcBad) begin
            next_secValid = 1'b1;
            next_secData = dnData;
            next_secLast = dnLast;
            next_secParity = evenParity(dnData) ^ dnPoisoned;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            secValid <= 1'b0;
            secData <= '0;
            secParity <= 1'b0;
            secLast <= 1'b0;
        end else begin
            secValid <= next_secValid;
            secData <= next_secData;
            secParity <= next_secParity;
            secLast <= next_secLast;
        end
    end

    // ------------------------------------------------------------------
    // Completion translation
    // ------------------------------------------------------------------
    logic next_cplValid;
    logic [2:0] next_cplStatus;
    logic next_cplPoisoned;
    logic dataErrEvent;

    assign dataErrEvent = termValid && (termKind == BES_TERM_DATAERR);

    always_comb begin
        next_cplValid = termValid;
        next_cplStatus = cplStatus;
        next_cplPoisoned = 1'b0;
        if (termValid) begin
            case (termKind)
                BES_TERM_NORMAL: next_cplStatus = BES_CPL_SC;
                BES_TERM_DATAERR: begin
                    if (termIsRead) begin
                        next_cplStatus = BES_CPL_SC;
                        next_cplPoisoned = 1'b1;
                    end else begin
                        next_cplStatus = BES_CPL_UR;
                    end
                end
                BES_TERM_MABORT: next_cplStatus = BES_CPL_UR;
                BES_TERM_TABORT: next_cplStatus = BES_CPL_CA;
                default: next_cplStatus = BES_CPL_UR;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cplValid <= 1'b0;
            cplStatus <= BES_CPL_SC;
            cplPoisoned <= 1'b0;
        end else begin
            cplValid <= next_cplValid;
            cplStatus <= next_cplStatus;
            cplPoisoned <= next_cplPoisoned;
        end
    end

    // ------------------------------------------------------------------
    // Error classification and status
    // ------------------------------------------------------------------
    logic [BES_NCLASS-1:0] next_severityFatal;
    logic [BES_NCLASS-1:0] errEvent;
    logic [BES_NCLASS-1:0] next_uncorrStatus;
    logic next_fatal_seen;
    logic next_nonfatal_seen;
    logic next_correctable_seen;
    logic next_parityDetected;
    logic next_systemErrorSignaled;
    logic next_advisorySeen;
    logic fatalAllowed;
    logic nonfatalAllowed;
    logic setFatal;
    logic setNonfatal;
    logic setCor;
    logic setSerr;
    logic setUncorr;
    logic [BES_NMSG-1:0] msgReq;

    assign errEvent = {dataErrEvent, ecrcEvent, poisonEvent};
    assign fatalAllowed = system_error_enable || fatal_report_enable;
    assign nonfatalAllowed = system_error_enable || nonfatal_report_enable;
    assign msgBus.request = msgReq;

    always_comb begin
        setFatal = 1'b0;
        setNonfatal = 1'b0;
        setCor = 1'b0;
        setSerr = 1'b0;
        setUncorr = 1'b0;
        msgReq = '0;
        next_uncorrStatus = uncorrStatus;
        next_advisorySeen = advisorySeen;
        next_severityFatal = severityWrite ? severityData : severityFatal;
        for (int c = 0; c < BES_NCLASS; c++) begin
            setUncorr = 1'b0;
            if (errEvent[c]) begin
                // Poison of nonfatal severity is an advisory error
                if (c == BES_CLS_POISON && !severityFatal[c]) begin
                    setCor = 1'b1;
                    next_advisorySeen = 1'b1;
                    if (!advisory_nonfatal_mask) begin
                        setUncorr = 1'b1;
                        if (correctable_report_enable) begin
                            msgReq[BES_REQ_COR] = 1'b1;
                        end
                    end
                end else begin
                    setUncorr = 1'b1;
                    if (severityFatal[c]) begin
                        setFatal = 1'b1;
                        if (!uncorrMask[c] && fatalAllowed) begin
                            msgReq[BES_REQ_FATAL] = 1'b1;
                            setSerr = setSerr || system_error_enable;
                        end
                    end else begin
                        setNonfatal = 1'b1;
                        if (!uncorrMask[c] && nonfatalAllowed) begin
                            msgReq[BES_REQ_NONFATAL] = 1'b1;
                            setSerr = setSerr || system_error_enable;
                        end
                    end
                end
            end
            // Set wins over a clear in the same cycle
            next_uncorrStatus[c] = setUncorr || (uncorrStatus[c] && !clearUncorrStatus[c]);
        end
        // seen bits set regardless of enables
        next_fatal_seen = setFatal || (fatal_seen && !clearFatalSeen);
        next_nonfatal_seen = setNonfatal || (nonfatal_seen && !clearNonfatalSeen);
        next_correctable_seen = setCor || (correctable_seen && !clearCorrectableSeen);
        next_advisorySeen = next_advisorySeen || (advisorySeen && !clearAdvisory);
        if (clearAdvisory && !(setCor && errEvent[BES_CLS_POISON])) begin
            next_advisorySeen = 1'b0;
        end
        next_parityDetected = (|errEvent) || (parityDetected && !clearParityDetected);
        next_systemErrorSignaled = setSerr || (systemErrorSignaled && !clearSystemErrorSignaled);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            severityFatal <= BES_SEV_RESET;
            uncorrStatus <= '0;
            fatal_seen <= 1'b0;
            nonfatal_seen <= 1'b0;
            correctable_seen <= 1'b0;
            parityDetected <= 1'b0;
            systemErrorSignaled <= 1'b0;
            advisorySeen <= 1'b0;
        end else begin
            severityFatal <= next_severityFatal;
            uncorrStatus <= next_uncorrStatus;
            fatal_seen <= next_fatal_seen;
            nonfatal_seen <= next_nonfatal_seen;
            correctable_seen <= next_correctable_seen;
            parityDetected <= next_parityDetected;
            systemErrorSignaled <= next_systemErrorSignaled;
            advisorySeen <= next_advisorySeen;
        end
    end

    // ------------------------------------------------------------------
    // Message sender
    // ------------------------------------------------------------------
    bes_msg_sender sender (
        .clk(clk),
        .rst_n(rst_n),
        .req(msgBus.sender),
        .requesterId(requesterId),
        .msgReady(msgReady),
        .msgValid(msgValid),
        .msgType(msgType),
        .msgRequesterId(msgRequesterId)
    );

endmodule

/* verification/bes_asserts.sv */
// Concurrent checks on the top ports of the downstream error block.
// Assumes one core clock; bound from the testbench top file.
`timescale 1ns/10ps
module bes_asserts
    import bes_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Reporting controls
    input wire logic system_error_enable,
    input wire logic fatal_report_enable,
    input wire logic nonfatal_report_enable,
    input wire logic correctable_report_enable,
    input wire logic [BES_IDW-1:0] requesterId,
    // Data path
    input wire logic dnValid,
    input wire logic dnPoisoned,
    input wire logic dnEcrcBad,
    input wire logic dnLast,
    input wire logic dnReady,
    input wire logic secReady,
    input wire logic secValid,
    input wire logic [BES_DW-1:0] secData,
    input wire logic secParity,
    // Completions
    input wire logic termValid,
    input wire bes_term_e termKind,
    input wire logic termIsRead,
    input wire logic cplValid,
    input wire logic [2:0] cplStatus,
    input wire logic cplPoisoned,
    // Status and messages
    input wire logic parityDetected,
    input wire logic [BES_NCLASS-1:0] uncorrStatus,
    input wire logic msgReady,
    input wire logic msgValid,
    input wire bes_msg_e msgType,
    input wire logic [BES_IDW-1:0] msgRequesterId
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    cpl_pulse_a: assert property (cplValid == $past(termValid))
        else $error("completion pulse not one cycle after termination");
    mabort_ur_a: assert property (termValid && termKind == BES_TERM_MABORT
        |=> cplStatus == BES_CPL_UR && !cplPoisoned) else $error("master abort not UR");
    tabort_ca_a: assert property (termValid && termKind == BES_TERM_TABORT
        |=> cplStatus == BES_CPL_CA && !cplPoisoned) else $error("target abort not CA");
    read_poison_a: assert property (termValid && termKind == BES_TERM_DATAERR && termIsRead
        |=> cplStatus == BES_CPL_SC && cplPoisoned) else $error("read data error completion");
    write_ur_a: assert property (termValid && termKind == BES_TERM_DATAERR && !termIsRead
        |=> cplStatus == BES_CPL_UR && !cplPoisoned) else $error("write data error completion");
    phase_parity_a: assert property (dnValid && dnReady && !dnEcrcBad
        |=> secValid && secParity == (^secData ^ $past(dnPoisoned))) else $error("bad parity");
    ecrc_drop_a: assert property (dnValid && dnReady && dnEcrcBad |=> !secValid)
        else $error("ECRC packet forwarded");
    ecrc_status_a: assert property (dnValid && dnReady && dnEcrcBad && dnLast
        |=> parityDetected && uncorrStatus[BES_CLS_ECRC]) else $error("ECRC status not set");
    fatal_gate_a: assert property ($rose(msgValid) && msgType == BES_MSG_FATAL
        |-> system_error_enable || fatal_report_enable) else $error("fatal message not enabled");
    nonfatal_gate_a: assert property ($rose(msgValid) && msgType == BES_MSG_NONFATAL
        |-> system_error_enable || nonfatal_report_enable) else $error("nonfatal not enabled");
    cor_gate_a: assert property ($rose(msgValid) && msgType == BES_MSG_COR
        |-> correctable_report_enable) else $error("correctable message not enabled");
    msg_hold_a: assert property (msgValid && !msgReady |=> msgValid && $stable(msgType))
        else $error("message dropped before handshake");
    msg_id_a: assert property (msgValid |-> msgRequesterId == requesterId)
        else $error("message requester id wrong");

    cover property ($rose(msgValid) && msgType == BES_MSG_COR);
    cover property ($rose(msgValid) && msgType == BES_MSG_FATAL);
    cover property (termValid && termKind == BES_TERM_DATAERR && termIsRead);
    cover property (dnValid && dnReady && dnPoisoned);
endmodule

/* verification/bes_far_model.sv */
// Far side model: secondary bus target and upstream message port.
// Ready may be throttled by the bench to make the block hold its outputs.
`timescale 1ns/10ps
module bes_far_model
    import bes_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Throttle request from the bench
    input wire logic stall,
    // Secondary bus side
    input wire logic secValid,
    input wire logic [BES_DW-1:0] secData,
    input wire logic secParity,
    output logic secReady,
    output logic [BES_DW:0] lastSec,
    output int secCount,
    // Upstream message side
    input wire logic msgValid,
    input wire bes_msg_e msgType,
    output logic msgReady,
    output bes_msg_e lastType,
    output int msgCount
);
    logic [2:0] tick;

    // Stalled secReady comes one cycle in four, stalled msgReady one in eight, so holding gets exercised
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 3'h0;
            secReady <= 1'b0;
            msgReady <= 1'b0;
            lastSec <= '0;
            secCount <= 0;
            lastType <= BES_MSG_COR;
            msgCount <= 0;
        end else begin
            tick <= tick + 3'h1;
            secReady <= !stall || (tick[1:0] == 2'h3);
            msgReady <= !stall || (tick == 3'h5);
            if (secValid && secReady) begin
                lastSec <= {secParity, secData};
                secCount <= secCount + 1;
            end
            if (msgValid && msgReady) begin
                lastType <= msgType;
                msgCount <= msgCount + 1;
            end
        end
    end
endmodule

/* verification/bridge_error_signaling_test.sv */
// Self-checking bench for the downstream error signalling block.
// Assumes the far side model answers on the secondary and message ports.
`timescale 1ns/10ps
module bridge_error_signaling_test;
    import bes_pkg::*;
    logic clk, rst_n, system_error_enable, fatal_report_enable, nonfatal_report_enable;
    logic correctable_report_enable, advisory_nonfatal_mask, severityWrite, stall;
    logic [BES_NCLASS-1:0] uncorrMask, severityData, severityFatal, clearUncorrStatus, uncorrStatus;
    logic [BES_IDW-1:0] requesterId, msgRequesterId;
    logic clearFatalSeen, clearNonfatalSeen, clearCorrectableSeen, clearParityDetected;
    logic clearSystemErrorSignaled, clearAdvisory, fatal_seen, nonfatal_seen, correctable_seen;
    logic parityDetected, systemErrorSignaled, advisorySeen, dnValid, dnPoisoned, dnEcrcBad;
    logic dnLast, dnReady, secReady, secValid, secParity, secLast, termValid, termIsRead;
    logic cplValid, cplPoisoned, msgReady, msgValid;
    logic [BES_DW-1:0] dnData, secData;
    logic [BES_DW:0] lastSec;
    logic [2:0] cplStatus;
    bes_term_e termKind;
    bes_msg_e msgType, lastType;
    int secCount, msgCount, errCount, checkCount;
    logic [2:0] expSt [8] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h1, 3'h1, 3'h4, 3'h4};
    logic expPz [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

    bridge_error_signaling dut (.*);
    bes_far_model far (.clk, .rst_n, .stall, .secValid, .secData, .secParity, .secReady,
        .lastSec, .secCount, .msgValid, .msgType, .msgReady, .lastType, .msgCount);

    task automatic finalReport;
        $display("checks=%0d errors=%0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Clears every sticky bit, sends one phase, lets messages drain
    task automatic evt(input logic [31:0] d, input logic p, input logic e);
        int n;
        n = 0;
        @(posedge clk);
        {clearFatalSeen, clearNonfatalSeen, clearCorrectableSeen} <= 3'h7;
        {clearParityDetected, clearSystemErrorSignaled, clearAdvisory} <= 3'h7;
        clearUncorrStatus <= 3'h7;
        @(posedge clk);
        {clearFatalSeen, clearNonfatalSeen, clearCorrectableSeen} <= 3'h0;
        {clearParityDetected, clearSystemErrorSignaled, clearAdvisory} <= 3'h0;
        clearUncorrStatus <= 3'h0;
        dnValid <= 1'b1;
        dnData <= d;
        dnPoisoned <= p;
        dnEcrcBad <= e;
        do begin
            @(negedge clk);
            n++;
        end while (!dnReady && n < 50);
        @(posedge clk);
        dnValid <= 1'b0;
        repeat (14) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic term(input int i);
        @(posedge clk);
        termValid <= 1'b1;
        termKind <= bes_term_e'(i >> 1);
        termIsRead <= i[0];
        @(posedge clk);
        termValid <= 1'b0;
        @(negedge clk);
        chk({29'h0, cplValid, cplStatus}, {29'h0, 1'b1, expSt[i]});
        chk(33'(cplPoisoned), 33'(expPz[i]));
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        finalReport();
    end

    initial begin
        {rst_n, system_error_enable, fatal_report_enable, nonfatal_report_enable} = 4'h0;
        {correctable_report_enable, advisory_nonfatal_mask, severityWrite, stall} = 4'h0;
        {uncorrMask, severityData, clearUncorrStatus} = 9'h0;
        {clearFatalSeen, clearNonfatalSeen, clearCorrectableSeen, clearParityDetected} = 4'h0;
        {clearSystemErrorSignaled, clearAdvisory, dnValid, dnPoisoned, dnEcrcBad} = 5'h0;
        {termValid, termIsRead} = 2'h0;
        termKind = BES_TERM_NORMAL;
        dnData = 32'h0;
        dnLast = 1'b1;
        requesterId = 16'h5a3c;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(33'(severityFatal), 33'(BES_SEV_RESET));
        chk(33'({fatal_seen, nonfatal_seen, correctable_seen, uncorrStatus}), 33'h0);
        evt(32'h1234_5678, 1'b0, 1'b1);
        chk(33'(secCount), 33'h0);
        chk(33'({fatal_seen, parityDetected, uncorrStatus}), 33'h1a);
        chk(33'(msgCount), 33'h0);
        fatal_report_enable <= 1'b1;
        evt(32'h1234_5678, 1'b0, 1'b1);
        chk({msgCount[31:0], 1'b0}, {32'h1, 1'b0});
        chk(33'({lastType, systemErrorSignaled}), 33'({BES_MSG_FATAL, 1'b0}));
        fatal_report_enable <= 1'b0;
        system_error_enable <= 1'b1;
        evt(32'h1234_5678, 1'b0, 1'b1);
        chk(33'({msgCount[3:0], lastType, systemErrorSignaled}), 33'({4'h2, BES_MSG_FATAL, 1'b1}));
        system_error_enable <= 1'b0;
        uncorrMask <= 3'h2;
        fatal_report_enable <= 1'b1;
        evt(32'h1234_5678, 1'b0, 1'b1);
        chk(33'({msgCount[3:0], fatal_seen}), 33'h5);
        uncorrMask <= 3'h0;
        severityWrite <= 1'b1;
        @(posedge clk);
        severityWrite <= 1'b0;
        @(negedge clk);
        chk(33'(severityFatal), 33'h0);
        nonfatal_report_enable <= 1'b1;
        evt(32'h1234_5678, 1'b0, 1'b1);
        chk(33'({msgCount[3:0], lastType, nonfatal_seen, fatal_seen}), 33'({4'h3, BES_MSG_NONFATAL, 2'h2}));
        evt(32'ha5a5_0f0f, 1'b1, 1'b0);
        chk(33'(lastSec), {~(^32'ha5a5_0f0f), 32'ha5a5_0f0f});
        chk(33'({correctable_seen, advisorySeen, nonfatal_seen}), 33'h6);
        chk(33'(msgCount), 33'h3);
        correctable_report_enable <= 1'b1;
        evt(32'ha5a5_0f0f, 1'b1, 1'b0);
        chk(33'({msgCount[3:0], lastType}), 33'({4'h4, BES_MSG_COR}));
        advisory_nonfatal_mask <= 1'b1;
        evt(32'ha5a5_0f0f, 1'b1, 1'b0);
        chk(33'({msgCount[3:0], advisorySeen, correctable_seen}), 33'h13);
        stall <= 1'b1;
        evt(32'h0000_0007, 1'b0, 1'b0);
        chk(33'(lastSec), {1'b1, 32'h0000_0007});
        evt(32'h0000_0003, 1'b0, 1'b0);
        chk(33'({secCount[3:0], lastSec}), {4'h5, 1'b0, 32'h0000_0003});
        for (int i = 0; i < 8; i++) begin
            term(i);
        end
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk(33'(lastType), 33'(BES_MSG_NONFATAL));
        finalReport();
    end
endmodule

bind bridge_error_signaling bes_asserts chkAsrt (.clk, .rst_n, .system_error_enable,
    .fatal_report_enable, .nonfatal_report_enable, .correctable_report_enable, .requesterId,
    .dnValid, .dnPoisoned, .dnEcrcBad, .dnLast, .dnReady, .secReady, .secValid, .secData,
    .secParity, .termValid, .termKind, .termIsRead, .cplValid, .cplStatus, .cplPoisoned,
    .parityDetected, .uncorrStatus, .msgReady, .msgValid, .msgType, .msgRequesterId);
